// [rtl/clk_synth_ctrl.sv]
// Serial register map, dividers, phase comparator and pump current control.
// Assumes ref_in, osc_in and serial pins are asynchronous and far below 12.5 MHz.
`timescale 1ns/1ps
module clk_synth_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic ref_in,
    input wire logic osc_in,
    output logic pump_up,
    output logic pump_down,
    output logic [3:0] pump_level,
    output logic [1:0] pump_test_field,
    output logic synth_enable,
    output logic osc_core_enable,
    output logic [1:0] osc_bias
);
    // ========================================================================
    // Pin synchronisers; edge detection compares the second and third stages
    logic [2:0] sclk_s, ref_s, osc_s;
    logic [1:0] cs_s, sdi_s;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_s <= 3'h0;
            cs_s <= 2'h3;
            sdi_s <= 2'h0;
            ref_s <= 3'h0;
            osc_s <= 3'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], spi_sclk};
            cs_s <= {cs_s[0], spi_cs_n};
            sdi_s <= {sdi_s[0], spi_sdi};
            ref_s <= {ref_s[1:0], ref_in};
            osc_s <= {osc_s[1:0], osc_in};
        end
    end
    wire sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire sclk_fall = ~sclk_s[1] & sclk_s[2];
    wire cs_active = ~cs_s[1];
    wire ref_edge = ref_s[1] & ~ref_s[2];
    wire osc_edge = osc_s[1] & ~osc_s[2];

    // ========================================================================
    // Register file
    logic [7:0] standby_controls_q;
    logic [1:0] osc_bias_q;
    logic [13:0] clock_reference_divisor_q;
    logic [12:0] clock_feedback_divisor_q;
    logic [6:0] pump_ctrl_q;
    logic [11:0] boost_period_divisor_q;

    function automatic logic [7:0] read_reg(input logic [6:0] a);
        case (a)
            clk_synth_pkg::ADDR_STANDBY: read_reg = standby_controls_q;
            clk_synth_pkg::ADDR_OSC_BIAS: read_reg = {4'h0, osc_bias_q, 2'h0};
            clk_synth_pkg::ADDR_REF_HIGH: read_reg = {2'h0, clock_reference_divisor_q[13:8]};
            clk_synth_pkg::ADDR_REF_LOW: read_reg = clock_reference_divisor_q[7:0];
            clk_synth_pkg::ADDR_FB_HIGH: read_reg = {3'h0, clock_feedback_divisor_q[12:8]};
            clk_synth_pkg::ADDR_FB_LOW: read_reg = clock_feedback_divisor_q[7:0];
            clk_synth_pkg::ADDR_PUMP_CTRL: read_reg = {1'b0, pump_ctrl_q};
            clk_synth_pkg::ADDR_BOOST_HIGH: read_reg = {4'h0, boost_period_divisor_q[11:8]};
            clk_synth_pkg::ADDR_BOOST_LOW: read_reg = boost_period_divisor_q[7:0];
            default: read_reg = 8'h00;
        endcase
    endfunction

    // ========================================================================
    // Serial slave: read flag, address, data, most significant bit first
    clk_synth_pkg::spi_state_type spi_state_q;
    logic [4:0] bit_cnt_q;
    logic [14:0] shift_in_q;
    logic [7:0] shift_out_q;
    logic is_read_q;
    wire [15:0] frame = {shift_in_q, sdi_s[1]};
    wire cmd_done = sclk_rise && (bit_cnt_q == clk_synth_pkg::SPI_CMD_BITS - 5'h01);
    wire frame_done = sclk_rise && (bit_cnt_q == clk_synth_pkg::SPI_FRAME_BITS - 5'h01);
    wire wr_en = frame_done && !is_read_q && spi_state_q == clk_synth_pkg::SPI_DATA;
    wire [6:0] wr_addr = frame[14:8];
    wire [7:0] wr_data = frame[7:0];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            spi_state_q <= clk_synth_pkg::SPI_IDLE;
            bit_cnt_q <= 5'h00;
            shift_in_q <= 15'h0000;
            shift_out_q <= 8'h00;
            is_read_q <= 1'b0;
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else if (!cs_active) begin
            spi_state_q <= clk_synth_pkg::SPI_IDLE;
            bit_cnt_q <= 5'h00;
            spi_sdo_oe <= 1'b0;
        end else begin
            case (spi_state_q)
                clk_synth_pkg::SPI_IDLE: begin
                    spi_state_q <= clk_synth_pkg::SPI_CMD;
                end
                clk_synth_pkg::SPI_CMD: begin
                    if (sclk_rise) begin
                        shift_in_q <= frame[14:0];
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                    end
                    if (cmd_done) begin
                        is_read_q <= frame[7];
                        shift_out_q <= read_reg(frame[6:0]);
                        spi_state_q <= clk_synth_pkg::SPI_DATA;
                    end
                end
                clk_synth_pkg::SPI_DATA: begin
                    if (sclk_rise) begin
                        shift_in_q <= frame[14:0];
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                    end
                    // Read data changes on the falling edge so the host samples it stable.
                    if (sclk_fall && is_read_q && bit_cnt_q != clk_synth_pkg::SPI_FRAME_BITS) begin
                        spi_sdo <= shift_out_q[7];
                        shift_out_q <= {shift_out_q[6:0], 1'b0};
                        spi_sdo_oe <= 1'b1;
                    end
                    if (frame_done) begin
                        spi_state_q <= clk_synth_pkg::SPI_IDLE;
                    end
                end
                default: spi_state_q <= clk_synth_pkg::SPI_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            standby_controls_q <= clk_synth_pkg::RST_STANDBY;
            osc_bias_q <= clk_synth_pkg::RST_OSC_BIAS;
            clock_reference_divisor_q <= clk_synth_pkg::RST_REF_DIV;
            clock_feedback_divisor_q <= clk_synth_pkg::RST_FB_DIV;
            pump_ctrl_q <= clk_synth_pkg::RST_PUMP_CTRL;
            boost_period_divisor_q <= clk_synth_pkg::RST_BOOST_DIV;
        end else if (wr_en) begin
            case (wr_addr)
                clk_synth_pkg::ADDR_STANDBY: standby_controls_q <= wr_data;
                clk_synth_pkg::ADDR_OSC_BIAS: osc_bias_q <= wr_data[clk_synth_pkg::BIAS_LSB +: 2];
                clk_synth_pkg::ADDR_REF_HIGH: clock_reference_divisor_q[13:8] <= wr_data[5:0];
                clk_synth_pkg::ADDR_REF_LOW: clock_reference_divisor_q[7:0] <= wr_data;
                clk_synth_pkg::ADDR_FB_HIGH: clock_feedback_divisor_q[12:8] <= wr_data[4:0];
                clk_synth_pkg::ADDR_FB_LOW: clock_feedback_divisor_q[7:0] <= wr_data;
                clk_synth_pkg::ADDR_PUMP_CTRL: pump_ctrl_q <= wr_data[6:0];
                clk_synth_pkg::ADDR_BOOST_HIGH: boost_period_divisor_q[11:8] <= wr_data[3:0];
                clk_synth_pkg::ADDR_BOOST_LOW: boost_period_divisor_q[7:0] <= wr_data;
                default: ;
            endcase
        end
    end

    // ========================================================================
    // Dividers and phase comparator; all held cleared in synthesizer standby
    wire synth_on = ~standby_controls_q[clk_synth_pkg::BLOCK_STANDBY_CONTROLS_SYNTH_BIT];
    wire boost_en = pump_ctrl_q[clk_synth_pkg::PUMP_BOOST_BIT];
    wire [2:0] pump_code = pump_ctrl_q[clk_synth_pkg::PUMP_CODE_LSB +: 3];
    logic [13:0] ref_cnt_q;
    logic [12:0] fb_cnt_q;
    logic [11:0] fa_cnt_q;
    logic up_q, dn_q;
    logic [2:0] width_t_q;
    logic [3:0] boost_mult_q;
    // A divisor of zero behaves as one rather than stalling the loop.
    wire ref_tick = ref_edge && (ref_cnt_q + 14'h0001 >= clock_reference_divisor_q);
    wire fb_tick = osc_edge && (fb_cnt_q + 13'h0001 >= clock_feedback_divisor_q);
    wire fa_tick = ref_edge && (fa_cnt_q + 12'h001 >= boost_period_divisor_q);
    wire up_d = (up_q | ref_tick) & ~(dn_q | fb_tick);
    wire dn_d = (dn_q | fb_tick) & ~(up_q | ref_tick);
    wire pulse_on = up_q | dn_q;
    wire pulse_start = (up_d | dn_d) & ~pulse_on;
    wire pulse_end = pulse_on & ~(up_d | dn_d);
    wire [3:0] pulse_mult = {1'b0, width_t_q} + 4'h1;
    wire [3:0] nominal = {1'b0, pump_code} + 4'h1;
    wire [3:0] boosted = (boost_mult_q > nominal) ? boost_mult_q : nominal;
    wire [3:0] floored = (pump_code == 3'h0 && boosted < clk_synth_pkg::PUMP_MULT_BOOST_FLOOR) ?
        clk_synth_pkg::PUMP_MULT_BOOST_FLOOR : boosted;
    wire [3:0] level_d = boost_en ? floored : nominal;
    wire inv = pump_ctrl_q[clk_synth_pkg::PUMP_INV_BIT];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_cnt_q <= 14'h0000;
            fb_cnt_q <= 13'h0000;
            fa_cnt_q <= 12'h000;
            up_q <= 1'b0;
            dn_q <= 1'b0;
            width_t_q <= 3'h0;
            boost_mult_q <= 4'h1;
        end else if (!synth_on) begin
            ref_cnt_q <= 14'h0000;
            fb_cnt_q <= 13'h0000;
            fa_cnt_q <= 12'h000;
            up_q <= 1'b0;
            dn_q <= 1'b0;
            width_t_q <= 3'h0;
            boost_mult_q <= 4'h1;
        end else begin
            if (ref_edge) ref_cnt_q <= ref_tick ? 14'h0000 : ref_cnt_q + 14'h0001;
            if (osc_edge) fb_cnt_q <= fb_tick ? 13'h0000 : fb_cnt_q + 13'h0001;
            up_q <= up_d;
            dn_q <= dn_d;
            // The T counter restarts with each pulse so widths are whole multiples of T.
            if (pulse_start) begin
                fa_cnt_q <= 12'h000;
                width_t_q <= 3'h0;
            end else if (ref_edge) begin
                fa_cnt_q <= fa_tick ? 12'h000 : fa_cnt_q + 12'h001;
                if (fa_tick && pulse_on && width_t_q != 3'h7) width_t_q <= width_t_q + 3'h1;
            end
            if (pulse_end) boost_mult_q <= pulse_mult;
        end
    end

    // ========================================================================
    // Output flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pump_up <= 1'b0;
            pump_down <= 1'b0;
            pump_level <= 4'h1;
            pump_test_field <= 2'h0;
            synth_enable <= 1'b0;
            osc_core_enable <= 1'b0;
            osc_bias <= 2'h0;
        end else begin
            pump_up <= synth_on & (inv ? dn_q : up_q);
            pump_down <= synth_on & (inv ? up_q : dn_q);
            pump_level <= level_d;
            pump_test_field <= pump_ctrl_q[1:0];
            synth_enable <= synth_on;
            osc_core_enable <= ~standby_controls_q[clk_synth_pkg::BLOCK_STANDBY_CONTROLS_OSC_BIT];
            osc_bias <= osc_bias_q;
        end
    end

    // ========================================================================
    // Checks
    a_standby_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        !synth_on |=> !pump_up && !pump_down && !synth_enable)
        else $error("pump active in standby");
    a_pump_exclusive: assert property (@(posedge sys_clk) disable iff (rst)
        !(pump_up && pump_down))
        else $error("pump up and down together");
    a_nominal_level: assert property (@(posedge sys_clk) disable iff (rst)
        !boost_en |=> pump_level == {1'b0, $past(pump_code)} + 4'h1)
        else $error("nominal pump level wrong");
    a_boost_floor: assert property (@(posedge sys_clk) disable iff (rst)
        boost_en && pump_code == 3'h0 |=> pump_level >= 4'h2)
        else $error("boost floor violated");
    a_level_ceiling: assert property (@(posedge sys_clk) disable iff (rst)
        pump_level <= clk_synth_pkg::PUMP_MULT_MAX && pump_level != 4'h0)
        else $error("pump level out of range");
    a_boost_raise_only: assert property (@(posedge sys_clk) disable iff (rst)
        boost_en |=> pump_level >= {1'b0, $past(pump_code)} + 4'h1)
        else $error("boost lowered the current");
    a_osc_follow: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(standby_controls_q[clk_synth_pkg::BLOCK_STANDBY_CONTROLS_OSC_BIT]) |=> !osc_core_enable)
        else $error("oscillator core not disabled");
    a_split_write: assert property (@(posedge sys_clk) disable iff (rst)
        wr_en && wr_addr == clk_synth_pkg::ADDR_REF_HIGH
        |=> clock_reference_divisor_q[13:8] == $past(wr_data[5:0]))
        else $error("reference high byte not stored");
    a_sdo_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !cs_active |=> !spi_sdo_oe)
        else $error("serial output driven while deselected");
endmodule

// [rtl/clk_synth_pkg.sv]
// Constants for the sampling clock synthesizer control block.
// Assumes a 25 MHz system clock and a byte-wide serial register map.
package clk_synth_pkg;
    // ========================================================================
    // Register offsets
    localparam logic [6:0] ADDR_STANDBY = 7'h00;
    localparam logic [6:0] ADDR_OSC_BIAS = 7'h01;
    localparam logic [6:0] ADDR_REF_HIGH = 7'h10;
    localparam logic [6:0] ADDR_REF_LOW = 7'h11;
    localparam logic [6:0] ADDR_FB_HIGH = 7'h12;
    localparam logic [6:0] ADDR_FB_LOW = 7'h13;
    localparam logic [6:0] ADDR_PUMP_CTRL = 7'h14;
    localparam logic [6:0] ADDR_BOOST_HIGH = 7'h15;
    localparam logic [6:0] ADDR_BOOST_LOW = 7'h16;
    // ========================================================================
    // Reset values
    localparam logic [7:0] RST_STANDBY = 8'hFF;
    localparam logic [1:0] RST_OSC_BIAS = 2'h0;
    localparam logic [13:0] RST_REF_DIV = 14'h0038;
    localparam logic [12:0] RST_FB_DIV = 13'h003C;
    localparam logic [6:0] RST_PUMP_CTRL = 7'h00;
    localparam logic [11:0] RST_BOOST_DIV = 12'h004;
    // ========================================================================
    // Field positions
    localparam int BLOCK_STANDBY_CONTROLS_OSC_BIT = 1;
    localparam int BLOCK_STANDBY_CONTROLS_SYNTH_BIT = 2;
    localparam int BIAS_LSB = 2;
    localparam int PUMP_BOOST_BIT = 6;
    localparam int PUMP_INV_BIT = 5;
    localparam int PUMP_CODE_LSB = 2;
    localparam int REF_HIGH_W = 6;
    localparam int FB_HIGH_W = 5;
    localparam int BOOST_HIGH_W = 4;
    // ========================================================================
    // Pump current in units of the minimum step
    localparam logic [3:0] PUMP_MULT_MAX = 4'h8;
    localparam logic [3:0] PUMP_MULT_BOOST_FLOOR = 4'h2;
    // ========================================================================
    // Serial frame: one read flag, seven address bits, eight data bits
    localparam logic [4:0] SPI_CMD_BITS = 5'h08;
    localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
    typedef enum logic [2:0] {
        SPI_IDLE = 3'b001,
        SPI_CMD = 3'b010,
        SPI_DATA = 3'b100
    } spi_state_type;
endpackage

// [tb/tank_model.sv]
// Behavioural stand-in for the external loop filter, varactor and LC tank.
// Assumes the bench tells it when to swing; it oscillates only with the core enabled.
`timescale 1ns/1ps
module tank_model #(
    parameter int HALF_NS = 400
) (
    input wire logic run,
    input wire logic core_enable,
    output logic osc_in
);
    // ========================================================================
    // Oscillation
    // The tank rests low when stopped so no stale level can pass for an edge.
    initial begin
        osc_in = 1'b0;
    end
    always begin
        if (run && core_enable) begin
            #HALF_NS osc_in = 1'b1;
            #HALF_NS osc_in = 1'b0;
        end else begin
            @(run or core_enable);
        end
    end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the clock synthesizer control block.
// Assumes the serial port and reference pin are driven slowly from this bench.
`timescale 1ns/1ps
module testbench;
    // ========================================================================
    // Signals
    logic sys_clk, rst, spi_sclk, spi_cs_n, spi_sdi, ref_in, osc_in, run;
    logic spi_sdo, spi_sdo_oe, pump_up, pump_down, synth_enable, osc_core_enable;
    logic [3:0] pump_level;
    logic [1:0] pump_test_field, osc_bias;
    logic [7:0] rd;
    logic oe_rd;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int i;
    logic [6:0] ra [10] = '{7'h00, 7'h01, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h20};
    logic [7:0] rv [10] = '{8'hFF, 8'h00, 8'h00, 8'h38, 8'h00, 8'h3C, 8'h00, 8'h00, 8'h04, 8'h00};
    clk_synth_ctrl i_clk_synth_ctrl (.sys_clk(sys_clk), .rst(rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .ref_in(ref_in), .osc_in(osc_in), .pump_up(pump_up), .pump_down(pump_down),
        .pump_level(pump_level), .pump_test_field(pump_test_field),
        .synth_enable(synth_enable), .osc_core_enable(osc_core_enable), .osc_bias(osc_bias));
    tank_model i_tank_model (.run(run), .core_enable(osc_core_enable), .osc_in(osc_in));
    // ========================================================================
    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            final_report();
        end
    end
    // ========================================================================
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Each half of the serial clock lasts five cycles so the synchroniser keeps up.
    task automatic spi(input logic [15:0] f);
        int k;
        spi_cs_n = 1'b0;
        cyc(5);
        for (k = 15; k >= 0; k--) begin
            spi_sdi = f[k];
            cyc(5);
            if (k < 8) rd[k] = spi_sdo;
            if (k == 0) oe_rd = spi_sdo_oe;
            spi_sclk = 1'b1;
            cyc(5);
            spi_sclk = 1'b0;
        end
        cyc(8);
        spi_cs_n = 1'b1;
        cyc(6);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spi({1'b0, a, d});
        check("sdo_oe_wr", 8'(oe_rd), 8'h00);
    endtask
    task automatic rdchk(input string name, input logic [6:0] a, input logic [7:0] exp);
        spi({1'b1, a, 8'h00});
        check(name, rd, exp);
        check("sdo_oe_on", 8'(oe_rd), 8'h01);
        check("sdo_oe_off", 8'(spi_sdo_oe), 8'h00);
    endtask
    task automatic ref_pulse(input int n);
        repeat (n) begin
            ref_in = 1'b1;
            cyc(6);
            ref_in = 1'b0;
            cyc(6);
        end
    endtask
    // One swing of the tank gives exactly one rising edge on the oscillator pin.
    task automatic osc_edge();
        int k;
        run = 1'b1;
        for (k = 0; k < 40 && osc_in !== 1'b1; k++) cyc(1);
        run = 1'b0;
        cyc(30);
    endtask
    task automatic final_report();
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ========================================================================
    // Sequence
    initial begin
        rst = 1'b1;
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
        ref_in = 1'b0;
        run = 1'b0;
        rd = 8'h00;
        cyc(3);
        rst = 1'b0;
        cyc(4);
        check("level_rst", 8'(pump_level), 8'h01);
        check("synth_rst", 8'(synth_enable), 8'h00);
        for (i = 0; i < 10; i++) rdchk("reg_rst", ra[i], rv[i]);
        wr(7'h10, 8'hFF);
        rdchk("ref_high", 7'h10, 8'h3F);
        wr(7'h12, 8'hFF);
        rdchk("fb_high", 7'h12, 8'h1F);
        wr(7'h15, 8'hFF);
        rdchk("boost_high", 7'h15, 8'h0F);
        wr(7'h20, 8'hAA);
        rdchk("unmapped", 7'h20, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(7'h01, 8'(i << 2));
            check("bias", 8'(osc_bias), 8'(i));
        end
        for (i = 0; i < 8; i++) begin
            wr(7'h14, 8'((i << 2) | (i & 3)));
            check("level_code", 8'(pump_level), 8'(i + 1));
            check("test_field", 8'(pump_test_field), 8'(i & 3));
        end
        wr(7'h10, 8'h00);
        wr(7'h11, 8'h03);
        wr(7'h12, 8'h00);
        wr(7'h13, 8'h01);
        wr(7'h15, 8'h00);
        wr(7'h16, 8'h02);
        wr(7'h14, 8'h00);
        check("level_off", 8'(pump_level), 8'h01);
        wr(7'h00, 8'hF9);
        check("synth_on", 8'(synth_enable), 8'h01);
        check("core_on", 8'(osc_core_enable), 8'h01);
        wr(7'h14, 8'h40);
        check("level_floor", 8'(pump_level), 8'h02);
        ref_pulse(2);
        check("up_early", 8'(pump_up), 8'h00);
        ref_pulse(1);
        check("up_set", 8'(pump_up), 8'h01);
        ref_pulse(7);
        osc_edge();
        check("up_clear", 8'(pump_up), 8'h00);
        check("down_clear", 8'(pump_down), 8'h00);
        check("level_boost", 8'(pump_level), 8'h04);
        wr(7'h14, 8'h54);
        check("level_nominal", 8'(pump_level), 8'h06);
        wr(7'h14, 8'h44);
        check("level_kept", 8'(pump_level), 8'h04);
        wr(7'h14, 8'h40);
        osc_edge();
        check("down_set", 8'(pump_down), 8'h01);
        ref_pulse(3);
        check("down_clear2", 8'(pump_down), 8'h00);
        osc_edge();
        // With the polarity bit set the pending down pulse must appear on the up pin.
        wr(7'h14, 8'h60);
        check("inv_up", 8'(pump_up), 8'h01);
        check("inv_down", 8'(pump_down), 8'h00);
        wr(7'h00, 8'hFD);
        check("synth_off", 8'(synth_enable), 8'h00);
        check("down_off", 8'(pump_down), 8'h00);
        check("up_off", 8'(pump_up), 8'h00);
        wr(7'h00, 8'hFF);
        check("core_off", 8'(osc_core_enable), 8'h00);
        final_report();
    end
endmodule
